// file: hw/wdcs_top.sv
// Watchdog timer with watchdog and system clock source selection
// Notes on behaviour
// - Counter clock: watchdog oscillator or system/4.
// - Disabled watchdog ignores all related actions.
// - Time-out at selected stage 2^12..2^15.
// - Clears reset only last two stages.
// - Running overflow: chip reset, set time-out flag.
// - Sleeping overflow: warm reset, set time-out flag, wake.
// - Cleared by reset pin, clears, sleep.
// - Single mode: single clear works, pair ignored.
// - Dual mode: both pair clears needed.
// - Without oscillator, counting may stop in sleep.
// - Watchdog oscillator keeps running in sleep.
// - Sleep stops system oscillator, ignores clock.
// - RC mode drives system/4 on out pin.
// - Option selects RC or crystal source.
// - Flags: time-out set, power-down set by sleep.
`timescale 1ns/1ps
`default_nettype none
module wdcs_top import wdcs_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Static options
  input wire wdcs_opt_t opt,
  // Clocks and pins
  input wire logic wd_osc_tick,
  input wire logic rc_osc_tick,
  input wire logic xtal_osc_tick,
  input wire logic external_clear_pin_n,
  input wire logic oscillator_in_pin,
  // Instruction events
  input wire wdcs_insn_t insn,
  input wire logic wake_event,
  // Outputs
  output logic chip_reset,
  output logic warm_reset,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic sleeping,
  output logic sys_clk_en,
  output logic oscillator_out_pin,
  output logic oscillator_out_oe_n,
  output logic [CNT_W-1:0] watchdog_counter
);
  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  wdcs_opt_t opt_ff, nxt_opt;
  wdcs_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic to_ff, nxt_to, pd_ff, nxt_pd;
  logic pair1_ff, nxt_pair1;
  logic chip_ff, nxt_chip, warm_ff, nxt_warm;
  logic sysen_ff, nxt_sysen, oout_ff, nxt_oout;
  logic sys_src, insn_tick, insn_half, wd_step, clr_any, ovf;
  logic [CNT_W-1:0] clr_mask;
  int unsigned top_bit;

  // --------------------------------------------------------------
  // System clock source and instruction clock
  // --------------------------------------------------------------
  always_comb begin
    sys_src = opt_ff.sys_rc_sel ? rc_osc_tick : xtal_osc_tick;
    sys_src = sys_src && (state_ff == RUN);
  end

  wdcs_prescale #(.DIV(INSN_DIV)) u_insn (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(sys_src),
    .tick(insn_tick),
    .half(insn_half)
  );

  // --------------------------------------------------------------
  // Watchdog counter
  // --------------------------------------------------------------
  always_comb begin
    top_bit = STAGE_MIN_LOG2 + 32'(opt_ff.stage_sel) - 1;
    // Watchdog oscillator runs in sleep; instruction clock does not
    if (opt_ff.wd_osc_sel && opt_ff.wd_osc_enable) begin
      wd_step = wd_osc_tick;
    end else begin
      wd_step = insn_tick;
    end
    clr_mask = '0;
    clr_mask[top_bit] = 1'b1;
    clr_mask[top_bit - 1] = 1'b1;
    ovf = opt_ff.wd_enable && wd_step && (&(cnt_ff | ~(clr_mask | (clr_mask - 16'h0001))));
    nxt_pair1 = pair1_ff;
    clr_any = 1'b0;
    if (opt_ff.dual_clear) begin
      if (insn.first_pair_clear_insn) begin
        nxt_pair1 = 1'b1;
      end
      if (insn.second_pair_clear_insn && (pair1_ff || insn.first_pair_clear_insn)) begin
        clr_any = 1'b1;
        nxt_pair1 = 1'b0;
      end
    end else begin
      clr_any = insn.single_clear_insn;
      nxt_pair1 = 1'b0;
    end
    clr_any = clr_any && opt_ff.wd_enable;
    nxt_cnt = cnt_ff;
    if (opt_ff.wd_enable && wd_step) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
    if (clr_any) begin
      nxt_cnt = cnt_ff & ~clr_mask;
    end
    if (ovf) begin
      nxt_cnt = CNT_RST;
    end
    if (!external_clear_pin_n || (insn.sleep_insn && state_ff == RUN && opt_ff.wd_enable)) begin
      nxt_cnt = CNT_RST;
      nxt_pair1 = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Sleep state, flags and resets
  // --------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_to = to_ff;
    nxt_pd = pd_ff;
    nxt_chip = 1'b0;
    nxt_warm = 1'b0;
    nxt_opt = opt_ff;
    case (state_ff)
      RUN: begin
        if (insn.sleep_insn) begin
          nxt_state = SLEEP;
          nxt_pd = 1'b1;
          nxt_to = 1'b0;
        end
        if (clr_any) begin
          nxt_to = 1'b0;
          nxt_pd = 1'b0;
        end
        if (ovf) begin
          nxt_chip = 1'b1;
          nxt_to = 1'b1;
          nxt_state = RUN;
        end
      end
      SLEEP: begin
        if (wake_event) begin
          nxt_state = RUN;
        end
        if (ovf) begin
          nxt_warm = 1'b1;
          nxt_to = 1'b1;
          nxt_state = RUN;
        end
      end
      default: nxt_state = RUN;
    endcase
    if (!external_clear_pin_n) begin
      nxt_chip = 1'b1;
      nxt_warm = 1'b0;
      nxt_state = RUN;
      if (state_ff == SLEEP) begin
        nxt_to = 1'b0;
      end
    end
    nxt_sysen = sys_src;
    nxt_oout = opt_ff.sys_rc_sel ? insn_half : oscillator_in_pin;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      opt_ff <= opt;
      state_ff <= RUN;
      cnt_ff <= CNT_RST;
      to_ff <= 1'b0;
      pd_ff <= 1'b0;
      pair1_ff <= 1'b0;
      chip_ff <= 1'b0;
      warm_ff <= 1'b0;
      sysen_ff <= 1'b0;
      oout_ff <= 1'b0;
    end else begin
      opt_ff <= nxt_opt;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      to_ff <= nxt_to;
      pd_ff <= nxt_pd;
      pair1_ff <= nxt_pair1;
      chip_ff <= nxt_chip;
      warm_ff <= nxt_warm;
      sysen_ff <= nxt_sysen;
      oout_ff <= nxt_oout;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign chip_reset = chip_ff;
  assign warm_reset = warm_ff;
  assign timeout_flag = to_ff;
  assign powerdown_flag = pd_ff;
  assign sleeping = (state_ff == SLEEP);
  assign sys_clk_en = sysen_ff;
  assign oscillator_out_pin = oout_ff;
  assign oscillator_out_oe_n = ~opt_ff.sys_rc_sel;
  assign watchdog_counter = cnt_ff;
endmodule // wdcs_top
`default_nettype wire

// file: inc/wdcs_pkg.sv
// Package for the watchdog timer with clock select
package wdcs_pkg;
  // --------------------------------------------------------------
  // Counts and widths
  // --------------------------------------------------------------
  localparam int unsigned INSN_DIV = 4;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned STAGE_MIN_LOG2 = 12;
  localparam logic [1:0] STAGE_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [1:0] DIV_RST = 2'h0;
  localparam logic [7:0] SP_ZERO = 8'h00;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef struct packed {
    logic wd_enable;
    logic wd_osc_sel;
    logic wd_osc_enable;
    logic [1:0] stage_sel;
    logic dual_clear;
    logic sys_rc_sel;
  } wdcs_opt_t;

  typedef struct packed {
    logic single_clear_insn;
    logic first_pair_clear_insn;
    logic second_pair_clear_insn;
    logic sleep_insn;
  } wdcs_insn_t;

  typedef enum logic [1:0] {RUN, SLEEP} wdcs_state_t;
endpackage : wdcs_pkg

// file: hw/wdcs_prescale.sv
// Divider that makes one-cycle enables from the system clock
`timescale 1ns/1ps
`default_nettype none
module wdcs_prescale import wdcs_pkg::*; #(
  parameter int unsigned DIV = INSN_DIV
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  output logic tick,
  output logic half
);
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (run) begin
      nxt_cnt = (cnt_ff == 2'(DIV - 1)) ? 2'h0 : cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_ff <= DIV_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tick = run && (cnt_ff == 2'(DIV - 1));
  assign half = cnt_ff[1];
endmodule // wdcs_prescale
`default_nettype wire

// file: dv/wdcs_top_sva.sv
// Assertion checker for the watchdog timer with clock select
`timescale 1ns/1ps
`default_nettype none
module wdcs_top_sva import wdcs_pkg::*; (
  // Clock, reset and inputs
  input wire logic ref_clk,
  input wire logic reset,
  input wire wdcs_opt_t opt,
  input wire logic external_clear_pin_n,
  input wire wdcs_insn_t insn,
  // Outputs
  input wire logic chip_reset,
  input wire logic warm_reset,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic sleeping,
  input wire logic oscillator_out_oe_n,
  input wire logic [CNT_W-1:0] watchdog_counter
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [CNT_W-1:0] clr_mask;
  assign clr_mask = 16'h0c00 << opt.stage_sel;
  pin_clear_a: assert property ($fell(external_clear_pin_n) |=> chip_reset && watchdog_counter == 16'h0)
    else $error("pin clear");
  single_clear_a: assert property (opt.wd_enable && !opt.dual_clear && insn == 4'h8 && external_clear_pin_n
    && watchdog_counter[9:0] != 10'h3ff |=> (watchdog_counter & clr_mask) == 16'h0) else $error("single clear");
  dual_clear_a: assert property (opt.wd_enable && opt.dual_clear && insn == 4'h6 && external_clear_pin_n
    && watchdog_counter[9:0] != 10'h3ff |=> (watchdog_counter & clr_mask) == 16'h0) else $error("dual clear");
  timeout_cause_a: assert property (chip_reset |-> timeout_flag || $past(!external_clear_pin_n))
    else $error("chip reset cause");
  warm_sleep_a: assert property (warm_reset |-> $past(sleeping) && timeout_flag && !chip_reset)
    else $error("warm reset cause");
  oe_mode_a: assert property (oscillator_out_oe_n == !opt.sys_rc_sel)
    else $error("out pin enable");
  disabled_a: assert property (!opt.wd_enable |=> !warm_reset && watchdog_counter == $past(watchdog_counter))
    else $error("disabled watchdog moved");
  sleep_entry_a: assert property (insn.sleep_insn && !sleeping && external_clear_pin_n |=> sleeping && powerdown_flag)
    else $error("sleep entry");
  cover property (warm_reset);
  cover property (chip_reset && timeout_flag);
  cover property (insn == 4'h6 && opt.dual_clear);
endmodule // wdcs_top_sva
bind wdcs_top wdcs_top_sva chk_u (.*);
`default_nettype wire

// file: dv/wdcs_top_tb.sv
// Self-checking bench for the watchdog timer with clock select
`timescale 1ns/1ps
`default_nettype none
module wdcs_top_tb import wdcs_pkg::*; ;
  logic ref_clk, reset, wd_osc_tick, external_clear_pin_n, wake_event, chip_reset, warm_reset;
  logic timeout_flag, powerdown_flag, sleeping, sys_clk_en, oscillator_out_pin, oscillator_out_oe_n;
  logic [CNT_W-1:0] watchdog_counter;
  wdcs_opt_t opt;
  wdcs_insn_t insn;
  int n_mismatch, checked, n;
  wdcs_top dut_u (.*, .rc_osc_tick(1'b1), .xtal_osc_tick(1'b1), .oscillator_in_pin(1'b0));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(string s, logic [19:0] seen, logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic step(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(logic [3:0] v);
    insn = v;
    step(1);
    insn = 4'h0;
  endtask
  task automatic boot(wdcs_opt_t o);
    opt = o;
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    chk("oe_n", oscillator_out_oe_n, !o.sys_rc_sel);
  endtask
  task automatic t_case(bit en, bit osc, bit [1:0] sel, bit dual, logic [3:0] a, logic [3:0] b, int e);
    int lim;
    lim = e ? e : 8000;
    boot('{en, osc, osc, sel, dual, osc});
    step(2999);
    pulse(a);
    step(9);
    pulse(b);
    for (n = 3010; n < lim + 8 && !chip_reset; n++) begin
      step(1);
    end
    chk("wait", 20'(n > lim - 9 && n < lim + 8 + !e), 20'h1);
    chk("timeout_flag", timeout_flag, e != 0);
    if (e && n == lim + 8) finish_test();
  endtask
  task automatic t_sleep(bit osc);
    boot('{1'b1, osc, osc, 2'h0, 1'b0, 1'b0});
    step(49);
    pulse(4'h1);
    chk("sleep", {sleeping, powerdown_flag, timeout_flag, watchdog_counter}, {3'b110, 16'h0});
    for (n = 0; n < (osc ? 4200 : 300) && !warm_reset; n++) begin
      step(1);
    end
    chk("warm", {warm_reset, chip_reset, timeout_flag, sys_clk_en}, {osc, 1'b0, osc, 1'b0});
    if (!osc) chk("stopped", watchdog_counter, 16'h0);
    if (osc && n == 4200) finish_test();
    external_clear_pin_n = 1'b0;
    step(1);
    external_clear_pin_n = 1'b1;
    chk("pin", {chip_reset, watchdog_counter}, {1'b1, 16'h0});
  endtask
  task automatic t_wake();
    logic [7:0] v;
    boot('{1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b1});
    pulse(4'h1);
    step(3);
    wake_event = 1'b1;
    step(1);
    wake_event = 1'b0;
    step(2);
    chk("wake", {sleeping, sys_clk_en}, 2'b01);
    for (int i = 0; i < 8; i++) begin
      v[i] = oscillator_out_pin;
      step(1);
    end
    chk("out_pin", {v[3:0] == v[7:4], 3'($countones(v[3:0]))}, {1'b1, 3'h2});
  endtask
  initial begin
    n_mismatch = 0;
    checked = 0;
    insn = 4'h0;
    wd_osc_tick = 1'b1;
    external_clear_pin_n = 1'b1;
    wake_event = 1'b0;
    t_case(1, 1, 0, 0, 4'h0, 4'h0, 4096);
    t_case(1, 1, 2, 0, 4'h0, 4'h0, 16384);
    t_case(1, 0, 0, 0, 4'h0, 4'h0, 16384);
    t_case(1, 1, 0, 0, 4'h8, 4'h0, 6144);
    t_case(1, 1, 0, 0, 4'h4, 4'h2, 4096);
    t_case(1, 1, 0, 1, 4'h8, 4'h0, 4096);
    t_case(1, 1, 0, 1, 4'h4, 4'h2, 6144);
    t_case(1, 1, 0, 1, 4'h6, 4'h0, 6144);
    t_case(0, 1, 0, 0, 4'h8, 4'h0, 0);
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_wake();
    finish_test();
  end
endmodule // wdcs_top_tb
`default_nettype wire
